// ### verilog/ssar_readout.sv
// Conversion control and serial result readout of a 12-bit sampling converter
//
// Summary of operation
// - Strobe rise starts conversion, internally timed
// - Enter nap automatically after each conversion
// - Serial output high impedance while strobe high
// - Strobe fall enables output, presents MSB
// - Output changes on falling shift edges and when a finished conversion updates the result
// - Twelve bits MSB first, then zeros forever
// - Readout carries the conversion just finished
// - Strobe low tracks; sample held at rise
// - One pulse naps after its conversion, four pulses sleep
// - One shift clock pulse wakes the device
`timescale 1ns/100ps
`default_nettype none

module ssar_readout #(
    parameter int RESULT_BITS = ssar_pkg::RESULT_BITS,
    parameter int CONVERT_STROBE_CYCLES = ssar_pkg::CONVERT_STROBE_CYCLES
) (
    // System clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst_n,
    // Host pins
    input  wire logic                       i_convert_strobe,
    input  wire logic                       i_shift_clk,
    output logic                            o_serial_result_out,
    output logic                            o_serial_result_oe,
    // Analog front end code, on the system clock
    input  wire logic [RESULT_BITS-1:0]     i_sample_code,
    // Status
    output ssar_pkg::ssar_status_t          o_status,
    output logic [RESULT_BITS-1:0]          o_last_result
);

    // ---------------- System clock domain ----------------
    logic                          strobe_s1_q;
    logic                          strobe_s2_q;
    logic                          strobe_s3_q;
    logic                          act_s1_q;
    logic                          act_s2_q;
    logic                          act_s3_q;
    ssar_pkg::ssar_state_t         state_q;
    ssar_pkg::ssar_state_t         state_d;
    logic [5:0]                    convert_strobe_cnt_q;
    logic [5:0]                    convert_strobe_cnt_d;
    logic [2:0]                    pulse_cnt_q;
    logic [2:0]                    pulse_cnt_d;
    logic [RESULT_BITS-1:0]        hold_q;
    logic [RESULT_BITS-1:0]        hold_d;
    logic [RESULT_BITS-1:0]        result_q;
    logic [RESULT_BITS-1:0]        result_d;
    ssar_pkg::ssar_status_t        status_q;
    ssar_pkg::ssar_status_t        status_d;
    logic                          strobe_rise;
    logic                          shift_activity;
    logic [2:0]                    pulse_next;
    // Shift-domain activity toggle, read here only through the synchroniser
    logic                          act_toggle_q;
    logic                          act_toggle_d;

    localparam logic [5:0] CONVERT_STROBE_LAST = 6'(CONVERT_STROBE_CYCLES - 1);

    // Two-flop synchronisers for the strobe pin and the shift-clock activity toggle
    // The third stages only keep the prior sample for the edge detectors
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            strobe_s1_q <= 1'b0;
            strobe_s2_q <= 1'b0;
            strobe_s3_q <= 1'b0;
            act_s1_q    <= 1'b0;
            act_s2_q    <= 1'b0;
            act_s3_q    <= 1'b0;
        end else begin
            strobe_s1_q <= i_convert_strobe;
            strobe_s2_q <= strobe_s1_q;
            strobe_s3_q <= strobe_s2_q;
            act_s1_q    <= act_toggle_q;
            act_s2_q    <= act_s1_q;
            act_s3_q    <= act_s2_q;
        end
    end

    assign strobe_rise    = strobe_s2_q & ~strobe_s3_q;
    assign shift_activity = act_s2_q ^ act_s3_q;
    // Pulse count saturates at the sleep count
    assign pulse_next     = (pulse_cnt_q == ssar_pkg::PULSES_SLEEP) ? pulse_cnt_q : pulse_cnt_q + 3'h1;

    // Power and conversion sequencing; a strobe rise outranks a wake seen in the same cycle
    always_comb begin
        state_d     = state_q;
        convert_strobe_cnt_d  = convert_strobe_cnt_q;
        pulse_cnt_d = pulse_cnt_q;
        hold_d      = hold_q;
        result_d    = result_q;
        // Strobe pulses are counted until the shift clock moves again
        if (strobe_rise) begin
            pulse_cnt_d = pulse_next;
        end else if (shift_activity) begin
            pulse_cnt_d = ssar_pkg::PULSE_CNT_RESET;
        end
        unique case (state_q)
            ssar_pkg::ST_AWAKE,
            ssar_pkg::ST_NAP: begin
                if (strobe_rise) begin
                    if (pulse_next == ssar_pkg::PULSES_SLEEP) begin
                        state_d = ssar_pkg::ST_SLEEP;
                    end else begin
                        hold_d     = i_sample_code;
                        convert_strobe_cnt_d = ssar_pkg::CONVERT_STROBE_CNT_RESET;
                        state_d    = ssar_pkg::ST_CONVERT;
                    end
                end else if (shift_activity) begin
                    state_d = ssar_pkg::ST_AWAKE;
                end
            end
            ssar_pkg::ST_CONVERT: begin
                // A rise during a conversion counts; one reaching the sleep count aborts it into sleep, others leave it running
                if (strobe_rise && pulse_next == ssar_pkg::PULSES_SLEEP) begin
                    state_d = ssar_pkg::ST_SLEEP;
                end else if (convert_strobe_cnt_q == CONVERT_STROBE_LAST) begin
                    result_d = hold_q;
                    state_d  = ssar_pkg::ST_NAP;
                end else begin
                    convert_strobe_cnt_d = convert_strobe_cnt_q + 6'h01;
                end
            end
            ssar_pkg::ST_SLEEP: begin
                // Only the shift clock wakes; strobe rises are merely counted
                if (!strobe_rise && shift_activity) begin
                    state_d = ssar_pkg::ST_AWAKE;
                end
            end
            default: begin
                state_d = ssar_pkg::ST_AWAKE;
            end
        endcase
        status_d.converting = (state_d == ssar_pkg::ST_CONVERT);
        status_d.napping    = (state_d == ssar_pkg::ST_NAP);
        status_d.sleeping   = (state_d == ssar_pkg::ST_SLEEP);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_q     <= ssar_pkg::ST_AWAKE;
            convert_strobe_cnt_q  <= ssar_pkg::CONVERT_STROBE_CNT_RESET;
            pulse_cnt_q <= ssar_pkg::PULSE_CNT_RESET;
            hold_q      <= ssar_pkg::RESULT_RESET;
            result_q    <= ssar_pkg::RESULT_RESET;
            status_q    <= ssar_pkg::STATUS_RESET;
        end else begin
            state_q     <= state_d;
            convert_strobe_cnt_q  <= convert_strobe_cnt_d;
            pulse_cnt_q <= pulse_cnt_d;
            hold_q      <= hold_d;
            result_q    <= result_d;
            status_q    <= status_d;
        end
    end

    assign o_status      = status_q;
    assign o_last_result = result_q;

    // ---------------- Shift clock domain ----------------
    logic [3:0]                    bit_cnt_q;
    logic [3:0]                    bit_cnt_d;
    logic [RESULT_BITS-1:0]        sel_bit;

    // Each rising shift edge flips this so the system side can see bus activity
    always_comb begin
        act_toggle_d = ~act_toggle_q;
    end

    always_ff @(posedge i_shift_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_toggle_q <= 1'b0;
        end else begin
            act_toggle_q <= act_toggle_d;
        end
    end

    // Bit index advances on falling edges and sticks past the LSB
    always_comb begin
        if (bit_cnt_q == ssar_pkg::BIT_CNT_LAST) begin
            bit_cnt_d = bit_cnt_q;
        end else begin
            bit_cnt_d = bit_cnt_q + 4'h1;
        end
    end

    // A high strobe rewinds the index so the MSB is ready when it falls
    always_ff @(negedge i_shift_clk or posedge i_convert_strobe) begin
        if (i_convert_strobe) begin
            bit_cnt_q <= ssar_pkg::BIT_CNT_RESET;
        end else begin
            bit_cnt_q <= bit_cnt_d;
        end
    end

    // The result word changes when a conversion ends, whatever the strobe level, so readout must follow that
    always_comb begin
        sel_bit = result_q >> (RESULT_BITS - 1 - int'(bit_cnt_q));
        if (bit_cnt_q < ssar_pkg::BIT_CNT_LAST) begin
            o_serial_result_out = sel_bit[0];
        end else begin
            o_serial_result_out = 1'b0;
        end
    end

    // Enable and data answer the strobe pin without a clock, as the MSB must stand at its fall;
    // a registered copy would show the old state until the next system edge
    assign o_serial_result_oe = ~i_convert_strobe;

endmodule // ssar_readout

`default_nettype wire

// ### shared/ssar_pkg.sv
// Package of constants, states and carriers for the serial sampling converter readout
package ssar_pkg;

    // Result width and stream layout
    localparam int RESULT_BITS = 12;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [3:0] BIT_CNT_LAST = 4'hC;

    // Conversion timing on the system clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_CONVERT_STROBE_NS = 1400;
    localparam int CONVERT_STROBE_CYCLES = (T_CONVERT_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONVERT_STROBE_CNT_W = 6;
    localparam logic [5:0] CONVERT_STROBE_CNT_RESET = 6'h00;

    // Strobe pulses with a static shift clock that command the power-down modes
    localparam logic [2:0] PULSE_CNT_RESET = 3'h0;
    localparam logic [2:0] PULSES_NAP = 3'h2;
    localparam logic [2:0] PULSES_SLEEP = 3'h4;

    localparam logic [11:0] RESULT_RESET = 12'h000;

    // Power and conversion states, one-hot
    typedef enum logic [3:0] {
        ST_AWAKE   = 4'b0001,
        ST_CONVERT = 4'b0010,
        ST_NAP     = 4'b0100,
        ST_SLEEP   = 4'b1000
    } ssar_state_t;

    // Status carried to the user side
    typedef struct packed {
        logic converting;
        logic napping;
        logic sleeping;
    } ssar_status_t;

    localparam ssar_status_t STATUS_RESET = 3'h0;

endpackage

// ### verification/ssar_readout_chk.sv
// Port assertions for the converter readout
`timescale 1ns/100ps
`default_nettype none
module ssar_readout_chk #(
    parameter int RESULT_BITS = 12,
    parameter int CONVERT_STROBE_CYCLES = 35
) (
    // Clock, reset, host pins
    input wire logic                   i_clk_sys,
    input wire logic                   i_rst_n,
    input wire logic                   i_convert_strobe,
    input wire logic                   i_shift_clk,
    input wire logic                   o_serial_result_out,
    input wire logic                   o_serial_result_oe,
    // Front end and status
    input wire logic [RESULT_BITS-1:0] i_sample_code,
    input wire ssar_pkg::ssar_status_t o_status,
    input wire logic [RESULT_BITS-1:0] o_last_result
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Conversion start and sleep entry must follow a strobe seen high 2 to 4 cycles earlier
    property p_cause(logic ev);
        ev |-> $past(i_convert_strobe, 2) || $past(i_convert_strobe, 3) || $past(i_convert_strobe, 4);
    endproperty
    a_oe_strobe: assert property (o_serial_result_oe == !i_convert_strobe) else $error("oe wrong");
    a_convert_strobe_cause: assert property (p_cause($rose(o_status.converting))) else $error("no strobe");
    a_convert_strobe_length: assert property ($rose(o_status.converting) |-> ##34 o_status.converting
        ##1 (o_status.napping && !o_status.converting)) else $error("conversion length");
    a_result_cause: assert property ($changed(o_last_result) |-> $past(o_status.converting)) else $error("stray");
    a_result_val: assert property ($fell(o_status.converting) |-> o_last_result == $past(i_sample_code, 36))
        else $error("result value");
    a_sleep_cause: assert property (p_cause($rose(o_status.sleeping))) else $error("sleep");
    a_msb_first: assert property ($fell(i_convert_strobe) |-> o_serial_result_out == o_last_result[RESULT_BITS-1])
        else $error("msb");
    a_state_one: assert property ($onehot0(o_status)) else $error("status");
    c_nap: cover property ($rose(o_status.napping));
    c_sleep: cover property ($rose(o_status.sleeping));
    c_read: cover property ($fell(i_convert_strobe));
endmodule // ssar_readout_chk
`default_nettype wire

// ### verification/ssar_host.sv
// Host model driving the strobe and the shift clock
`timescale 1ns/100ps
`default_nettype none
module ssar_host (
    // System clock and data pin
    input  wire logic i_clk_sys,
    input  wire logic i_serial_result_out,
    // Strobe and link clock
    output logic      o_convert_strobe,
    output logic      o_shift_clk
);
    initial begin
        o_convert_strobe = 1'b0;
        o_shift_clk = 1'b0;
    end
    // High n cycles, then 1920 ns acquisition gap, so rises stand over 2000 ns apart
    task automatic strobe(input int n);
        @(posedge i_clk_sys) o_convert_strobe <= 1'b1;
        repeat (n) @(posedge i_clk_sys);
        o_convert_strobe <= 1'b0;
        repeat (48) @(posedge i_clk_sys);
    endtask
    task automatic wake();
        #3 o_shift_clk = 1'b1;
        #3 o_shift_clk = 1'b0;
    endtask
    task automatic read(output logic [15:0] w);
        w = 16'h0000;
        // Sample at the rising shift edge, well clear of the falling edge that moves the data
        repeat (16) begin
            #3 o_shift_clk = 1'b1;
            w = {w[14:0], i_serial_result_out};
            #3 o_shift_clk = 1'b0;
        end
        repeat (2) @(posedge i_clk_sys);
    endtask
endmodule // ssar_host
`default_nettype wire

// ### verification/test_serial_sampling_adc_readout.sv
// Testbench of the converter readout
`timescale 1ns/100ps
`default_nettype none
module test_serial_sampling_adc_readout;
    logic                   i_clk_sys, i_rst_n, cs, sck, serial_result_out, oe;
    logic [11:0]            code, last;
    logic [15:0]            w;
    ssar_pkg::ssar_status_t st;
    logic [11:0]            codes [4] = '{12'hA5C, 12'h800, 12'h001, 12'hFFF};
    int                     miscompares = 0;
    int                     n_compared = 0;
    ssar_readout DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_convert_strobe(cs), .i_shift_clk(sck),
        .o_serial_result_out(serial_result_out), .o_serial_result_oe(oe), .i_sample_code(code), .o_status(st), .o_last_result(last));
    ssar_host host (.i_clk_sys(i_clk_sys), .i_serial_result_out(serial_result_out), .o_convert_strobe(cs), .o_shift_clk(sck));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic t_readout(input logic [11:0] c);
        code <= c;
        // The front-end code moves during the conversion; the held sample must win
        fork
            host.strobe(40);
            begin
                repeat (8) @(posedge i_clk_sys);
                code <= ~c;
            end
        join
        chk("status", 16'(st), 16'h0002);
        chk("result", 16'(last), 16'(c));
        chk("oe", 16'(oe), 16'h0001);
        host.read(w);
        chk("stream", w, {c, 4'h0});
        repeat (4) @(posedge i_clk_sys);
        chk("awake", 16'(st), 16'h0000);
    endtask
    task automatic t_power();
        repeat (4) host.strobe(2);
        chk("sleep", 16'(st), 16'h0001);
        host.strobe(2);
        chk("sleep held", 16'(st), 16'h0001);
        host.wake();
        repeat (4) @(posedge i_clk_sys);
        chk("woken", 16'(st), 16'h0000);
        repeat (27500) @(posedge i_clk_sys);
        repeat (2) host.strobe(2);
        chk("nap", 16'(st), 16'h0002);
        host.wake();
        repeat (2) @(posedge i_clk_sys);
        t_readout(12'h5A3);
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        i_rst_n = 1'b0;
        code = 12'h000;
        repeat (16) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        foreach (codes[i]) t_readout(codes[i]);
        t_power();
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge i_clk_sys);
        miscompares++;
        print_verdict();
    end
endmodule // test_serial_sampling_adc_readout
bind ssar_readout ssar_readout_chk #(.RESULT_BITS(RESULT_BITS), .CONVERT_STROBE_CYCLES(CONVERT_STROBE_CYCLES)) u_chk (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_convert_strobe(i_convert_strobe), .i_shift_clk(i_shift_clk),
    .o_serial_result_out(o_serial_result_out), .o_serial_result_oe(o_serial_result_oe),
    .i_sample_code(i_sample_code), .o_status(o_status), .o_last_result(o_last_result));
`default_nettype wire
